// file: rtl/cmc_map.svh
// console manual control: offsets, field positions, reset values, timing counts
// assumes a 100 MHz processor clock; all times are converted to cycle counts here
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_CLK_MHZ          100
`define CMC_T_SS1_NS         1000
`define CMC_T_SS20_MS        20
`define CMC_T_SS350_US       350
`define CMC_T_PULSE_NS       200
`define CMC_T_SLOW_MS        104
`define CMC_T_FAST_MS        24
`define CMC_CYC_SS1          ((`CMC_T_SS1_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_CYC_SS20         (`CMC_T_SS20_MS * 1000 * `CMC_CLK_MHZ)
`define CMC_CYC_SS350        (`CMC_T_SS350_US * `CMC_CLK_MHZ)
`define CMC_CYC_PULSE        ((`CMC_T_PULSE_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_CYC_SLOW         (`CMC_T_SLOW_MS * 1000 * `CMC_CLK_MHZ)
`define CMC_CYC_FAST         (`CMC_T_FAST_MS * 1000 * `CMC_CLK_MHZ)
`define CMC_LOAD_WORDS       15'h0003
`define CMC_LOAD_TAPE_UNIT   4'h1
`define CMC_RESUME_ADDR      15'h0001
`define CMC_CW_ADDR          15'h0000
`define CMC_ADDR_LSB         0
`define CMC_ADDR_MSB         14
`define CMC_TAG_LSB          15
`define CMC_TAG_MSB          17
`define CMC_CLR_LSB          15
`define CMC_CLR_MSB          34
`endif

// file: rtl/cmc_pkg.sv
// console manual control: types shared by the design
// assumes cmc_map.svh supplies numeric constants
package cmc_pkg;
	typedef enum logic [2:0] {
		KEY_NONE,
		KEY_DEA,
		KEY_SSTEP,
		KEY_MSTEP,
		KEY_ENTMQ,
		KEY_ENTINS,
		KEY_LCARD,
		KEY_LTAPE
	} cmc_key_t;
	typedef enum logic [2:0] {
		DB_IDLE,
		DB_SS1,
		DB_SS20,
		DB_SS350,
		DB_PULSE,
		DB_WAIT_REL
	} cmc_db_t;
	typedef enum logic [1:0] {
		RUN_IDLE,
		RUN_BUSY,
		RUN_IO,
		RUN_GAP
	} cmc_run_t;
endpackage

// file: rtl/cmc_console.sv
// console manual control: debounce, key dispatch, stepping, loads, sense, cycle lamps
// assumes the processor sequencer answers each execute request with a done pulse
`include "cmc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cmc_console #(
	parameter int TIME_DIV = 1
) (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_B_IN,
	// operator keys and switches (pins, asynchronous)
	input  wire logic [6:0]  KEYS_IN,
	input  wire logic        MANUAL_IN,
	input  wire logic        CONT_ENTER_IN,
	input  wire logic        FAST_IN,
	input  wire logic        DISP_IND_IN,
	input  wire logic [35:0] ENTRY_IN,
	input  wire logic [5:0]  SENSE_SW_IN,
	// sequencer side
	input  wire logic        PROG_STOP_IN,
	input  wire logic        EXEC_DONE_IN,
	input  wire logic        HALT_IN,
	input  wire logic        IO_BUSY_IN,
	input  wire logic [14:0] INDEX_IN,
	input  wire logic [35:0] SR_IN,
	input  wire logic        LAMP_SET_IN,
	input  wire logic        LAMP_CLR_IN,
	input  wire logic [1:0]  LAMP_SEL_IN,
	input  wire logic        SENSE_TEST_IN,
	input  wire logic        SENSE_SW_SEL_IN,
	input  wire logic [2:0]  SENSE_IDX_IN,
	input  wire logic [3:0]  CYCLE_REQ_IN,
	// outputs
	output logic             EXEC_REQ_OUT,
	output logic             EXEC_ENTRY_OUT,
	output logic [35:0]      EXEC_WORD_OUT,
	output logic             SR_LOAD_OUT,
	output logic [35:0]      SR_OUT,
	output logic             MQ_LOAD_OUT,
	output logic [35:0]      MQ_OUT,
	output logic             LOAD_RESET_OUT,
	output logic             LOAD_PULSE_OUT,
	output logic             LOAD_TAPE_OUT,
	output logic [3:0]       LOAD_UNIT_OUT,
	output logic [14:0]      LOAD_COUNT_OUT,
	output logic [14:0]      CPU_RESUME_OUT,
	output logic [14:0]      CHAN_CW_OUT,
	output logic             SKIP_OUT,
	output logic [3:0]       SENSE_LAMP_OUT,
	output logic [3:0]       CYCLE_LAMP_OUT,
	output logic             MULT_ERR_OUT,
	output logic             STOPPED_OUT
);
	typedef struct packed {
		logic [2:0][6:0]     key_s;
		logic [2:0]          man_s;
		logic [2:0]          ce_s;
		logic [2:0]          fast_s;
		logic [2:0]          di_s;
		logic [6:0]          keys;
		logic                man;
		cmc_pkg::cmc_db_t    db;
		logic [6:0]          db_key;
		logic [31:0]         tmr;
		logic                mct;
		cmc_pkg::cmc_run_t   run;
		logic                multi;
		logic                exec_req;
		logic                exec_entry;
		logic [35:0]         exec_word;
		logic                sr_load;
		logic [35:0]         sr;
		logic                mq_load;
		logic [35:0]         mq;
		logic                ld_reset;
		logic                ld_pulse;
		logic [7:0]          ld_cnt;
		logic [7:0]          lp_len;
		logic                ld_tape;
		logic [3:0]          ld_unit;
		logic [14:0]         ld_count;
		logic [14:0]         cpu_resume;
		logic [14:0]         chan_cw;
		logic                skip;
		logic [3:0]          lamps;
		logic [3:0]          cyc;
		logic                merr;
		logic                stopped;
	} cmc_state_t;

	cmc_state_t s_q;
	cmc_state_t s_d;

	// a change counts once the second and third stages agree
	function automatic logic settle(input logic [2:0] sh, input logic old);
		settle = (sh[1] == sh[2]) ? sh[2] : old;
	endfunction

	// debounce and gap timers divide by TIME_DIV so a bench can shorten them; 1 keeps the real timing
	function automatic logic [31:0] scaled(input int n);
		scaled = (n / TIME_DIV > 1) ? 32'(n / TIME_DIV) : 32'h0000_0001;
	endfunction

	function automatic logic [14:0] eff_addr(input logic [14:0] a, input logic [14:0] x);
		eff_addr = a + (~x + 15'h0001);
	endfunction

	logic [6:0] edge_k;
	logic       man_ok;
	logic       step_ok;
	logic       ms_ok;

	always_comb begin
		s_d = s_q;
		edge_k = '0;
		s_d.key_s = {s_q.key_s[1:0], KEYS_IN};
		s_d.man_s = {s_q.man_s[1:0], MANUAL_IN};
		s_d.ce_s = {s_q.ce_s[1:0], CONT_ENTER_IN};
		s_d.fast_s = {s_q.fast_s[1:0], FAST_IN};
		s_d.di_s = {s_q.di_s[1:0], DISP_IND_IN};
		for (int i = 0; i < 7; i++) begin
			s_d.keys[i] = settle({s_q.key_s[2][i], s_q.key_s[1][i], 1'b0}, s_q.keys[i]);
		end
		s_d.man = settle(s_q.man_s, s_q.man);
		s_d.exec_req = 1'b0;
		s_d.sr_load = 1'b0;
		s_d.mq_load = 1'b0;
		s_d.ld_reset = 1'b0;
		s_d.skip = 1'b0;
		s_d.mct = 1'b0;
		man_ok = s_q.man;
		step_ok = man_ok && !PROG_STOP_IN;
		ms_ok = man_ok && PROG_STOP_IN;
		// timed pulse chain per press
		case (s_q.db)
			cmc_pkg::DB_IDLE: begin
				if (s_q.keys != 7'h00) begin
					s_d.db = cmc_pkg::DB_SS1;
					s_d.db_key = s_q.keys;
					s_d.tmr = scaled(`CMC_CYC_SS1);
				end
			end
			cmc_pkg::DB_SS1, cmc_pkg::DB_SS20, cmc_pkg::DB_SS350, cmc_pkg::DB_PULSE: begin
				if (s_q.tmr > 32'h0000_0001) begin
					s_d.tmr = s_q.tmr - 32'h0000_0001;
				end else if (s_q.db == cmc_pkg::DB_SS1) begin
					s_d.db = cmc_pkg::DB_SS20;
					s_d.tmr = scaled(`CMC_CYC_SS20);
				end else if (s_q.db == cmc_pkg::DB_SS20) begin
					s_d.db = cmc_pkg::DB_SS350;
					s_d.tmr = scaled(`CMC_CYC_SS350);
				end else if (s_q.db == cmc_pkg::DB_SS350) begin
					s_d.db = cmc_pkg::DB_PULSE;
					s_d.tmr = scaled(`CMC_CYC_PULSE);
				end else begin
					s_d.db = cmc_pkg::DB_WAIT_REL;
					s_d.mct = 1'b1;
				end
			end
			cmc_pkg::DB_WAIT_REL: begin
				if (s_q.keys == 7'h00) begin
					s_d.db = cmc_pkg::DB_IDLE;
				end
			end
			default: s_d.db = cmc_pkg::DB_IDLE;
		endcase
		if (s_q.mct) begin
			edge_k = s_q.db_key;
		end
		// key dispatch; a key out of its status is dropped entirely
		if (s_q.run == cmc_pkg::RUN_IDLE && !s_q.ld_pulse) begin
			if (edge_k[0] && man_ok) begin
				s_d.sr = {SR_IN[35], 20'h0_0000,
					eff_addr(SR_IN[`CMC_ADDR_MSB:`CMC_ADDR_LSB], INDEX_IN)};
				s_d.sr_load = 1'b1;
			end else if (edge_k[1] && step_ok) begin
				s_d.run = cmc_pkg::RUN_BUSY;
				s_d.exec_req = 1'b1;
				s_d.exec_entry = s_q.ce_s[2] & s_q.ce_s[1];
				s_d.exec_word = ENTRY_IN;
				s_d.multi = 1'b0;
			end else if (edge_k[2] && ms_ok) begin
				s_d.run = cmc_pkg::RUN_BUSY;
				s_d.exec_req = 1'b1;
				s_d.exec_entry = s_q.ce_s[2] & s_q.ce_s[1];
				s_d.exec_word = ENTRY_IN;
				s_d.multi = 1'b1;
			end else if (edge_k[3] && man_ok) begin
				s_d.mq = ENTRY_IN;
				s_d.mq_load = 1'b1;
			end else if (edge_k[4] && man_ok) begin
				s_d.run = cmc_pkg::RUN_BUSY;
				s_d.exec_req = 1'b1;
				s_d.exec_entry = 1'b1;
				s_d.exec_word = ENTRY_IN;
				s_d.multi = 1'b0;
			end else if (edge_k[5] || edge_k[6]) begin
				s_d.ld_reset = 1'b1;
				s_d.ld_pulse = 1'b1;
				s_d.ld_cnt = 8'(`CMC_CYC_SS1);
				s_d.ld_tape = edge_k[6];
				s_d.ld_unit = edge_k[6] ? `CMC_LOAD_TAPE_UNIT : 4'h0;
				s_d.ld_count = `CMC_LOAD_WORDS;
				s_d.cpu_resume = `CMC_RESUME_ADDR;
				s_d.chan_cw = `CMC_CW_ADDR;
			end
		end
		s_d.lp_len = s_q.ld_pulse ? s_q.lp_len + 8'h01 : 8'h00;
		if (s_q.ld_pulse) begin
			s_d.ld_cnt = s_q.ld_cnt - 8'h01;
			if (s_q.ld_cnt == 8'h01) begin
				s_d.ld_pulse = 1'b0;
			end
		end
		// stepping sequencer
		case (s_q.run)
			cmc_pkg::RUN_IDLE: ;
			cmc_pkg::RUN_BUSY: begin
				if (EXEC_DONE_IN) begin
					if (IO_BUSY_IN) begin
						s_d.run = cmc_pkg::RUN_IO;
						s_d.exec_req = 1'b1;
						s_d.exec_entry = 1'b0;
					end else if (s_q.multi && !HALT_IN && s_q.keys[2]) begin
						s_d.run = cmc_pkg::RUN_GAP;
						s_d.tmr = (s_q.fast_s[2] & s_q.fast_s[1]) ? scaled(`CMC_CYC_FAST)
							: scaled(`CMC_CYC_SLOW);
					end else begin
						s_d.run = cmc_pkg::RUN_IDLE;
					end
				end
			end
			cmc_pkg::RUN_IO: begin
				if (EXEC_DONE_IN) begin
					if (IO_BUSY_IN) begin
						s_d.exec_req = 1'b1;
					end else begin
						s_d.run = cmc_pkg::RUN_IDLE;
					end
				end
			end
			cmc_pkg::RUN_GAP: begin
				if (!s_q.keys[2] || !s_q.man) begin
					s_d.run = cmc_pkg::RUN_IDLE;
				end else if (s_q.tmr > 32'h0000_0001) begin
					s_d.tmr = s_q.tmr - 32'h0000_0001;
				end else begin
					s_d.run = cmc_pkg::RUN_BUSY;
					s_d.exec_req = 1'b1;
				end
			end
			default: s_d.run = cmc_pkg::RUN_IDLE;
		endcase
		// sense lamps and switches
		if (LAMP_SET_IN) begin
			s_d.lamps[LAMP_SEL_IN] = 1'b1;
		end else if (LAMP_CLR_IN) begin
			s_d.lamps[LAMP_SEL_IN] = 1'b0;
		end
		if (SENSE_TEST_IN) begin
			s_d.skip = SENSE_SW_SEL_IN ? (SENSE_IDX_IN < 3'h6 && SENSE_SW_IN[SENSE_IDX_IN])
				: s_q.lamps[SENSE_IDX_IN[1:0]];
		end
		if (settle(s_q.di_s, 1'b0) && !s_d.sr_load) begin
			s_d.sr = {32'h0000_0000, s_q.lamps};
			s_d.sr_load = 1'b1;
		end
		s_d.cyc = CYCLE_REQ_IN;
		s_d.merr = ($countones(CYCLE_REQ_IN) > 1) && (CYCLE_REQ_IN != 4'b1100);
		s_d.stopped = s_q.man && (s_d.run == cmc_pkg::RUN_IDLE);
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign EXEC_REQ_OUT = s_q.exec_req;
	assign EXEC_ENTRY_OUT = s_q.exec_entry;
	assign EXEC_WORD_OUT = s_q.exec_word;
	assign SR_LOAD_OUT = s_q.sr_load;
	assign SR_OUT = s_q.sr;
	assign MQ_LOAD_OUT = s_q.mq_load;
	assign MQ_OUT = s_q.mq;
	assign LOAD_RESET_OUT = s_q.ld_reset;
	assign LOAD_PULSE_OUT = s_q.ld_pulse;
	assign LOAD_TAPE_OUT = s_q.ld_tape;
	assign LOAD_UNIT_OUT = s_q.ld_unit;
	assign LOAD_COUNT_OUT = s_q.ld_count;
	assign CPU_RESUME_OUT = s_q.cpu_resume;
	assign CHAN_CW_OUT = s_q.chan_cw;
	assign SKIP_OUT = s_q.skip;
	assign SENSE_LAMP_OUT = s_q.lamps;
	assign CYCLE_LAMP_OUT = s_q.cyc;
	assign MULT_ERR_OUT = s_q.merr;
	assign STOPPED_OUT = s_q.stopped;

	a_mq_manual_only: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		MQ_LOAD_OUT |-> $past(s_q.man)) else $error("quotient load outside manual");
	a_step_gate: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		(s_q.mct && s_q.db_key[1] && (!s_q.man || PROG_STOP_IN) && s_q.run == cmc_pkg::RUN_IDLE)
		|=> !EXEC_REQ_OUT) else $error("step taken outside manual");
	a_ea_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		(SR_LOAD_OUT && $past(s_q.mct)) |-> SR_OUT[34:15] == 20'h0_0000)
		else $error("positions not cleared");
	a_load_count: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		$rose(LOAD_RESET_OUT) |-> LOAD_COUNT_OUT == 15'h0003 && CPU_RESUME_OUT == 15'h0001)
		else $error("load setup wrong");
	a_load_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		$fell(LOAD_PULSE_OUT) |-> s_q.lp_len == 8'(`CMC_CYC_SS1))
		else $error("load pulse not one microsecond");
	a_merr_share: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		(CYCLE_REQ_IN == 4'b1100) |=> !MULT_ERR_OUT) else $error("share flagged");
	a_merr_double: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		(CYCLE_REQ_IN == 4'b0011) |=> MULT_ERR_OUT) else $error("double missed");
	a_io_runon: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		(s_q.run != cmc_pkg::RUN_IDLE && EXEC_DONE_IN && IO_BUSY_IN) |=> EXEC_REQ_OUT)
		else $error("stopped during io");
endmodule
`default_nettype wire

// file: bench/cmc_seq_model.sv
// sequencer model: answers each execute request with a done pulse after a set latency
// assumes requests rise on a clock edge; io stays busy for io_n_in further instructions
`timescale 1ns/1ps
`default_nettype none
module cmc_seq_model (
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       req_in,
	input  wire logic [3:0] lat_in,
	input  wire logic [3:0] io_n_in,
	output logic            done_out,
	output logic            io_busy_out
);
	logic       req_q;
	logic       act_q;
	logic [3:0] wait_q;
	logic [3:0] cnt_q;
	// io counts its own instructions, so a step that starts io keeps the console busy
	assign io_busy_out = act_q && (cnt_q < io_n_in);
	always_ff @(posedge clk_in) begin
		req_q <= req_in;
		done_out <= rst_b_in && (wait_q == 4'h1);
		if (!rst_b_in) begin
			wait_q <= 4'h0;
		end else if (req_in && !req_q) begin
			wait_q <= lat_in + 4'h1;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end
		if (!rst_b_in || io_n_in == 4'h0) begin
			act_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (req_in && !req_q) begin
			act_q <= 1'b1;
		end else if (done_out && act_q) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: bench/test_console_manual_control.sv
// self-checking bench: sense, cycle lamps, then one key press per scenario
// assumes the design's debounce and gap timers divided by DIV, so each press costs about two thousand cycles
`include "cmc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_console_manual_control;
	localparam int DIV = 1000;
	// the 1 us and 200 ns stages floor to one cycle each once divided
	localparam int HOLD = `CMC_CYC_SS20 / DIV + `CMC_CYC_SS350 / DIV + 2 + 60;
	logic        clk = 1'b0, rst_b = 1'b0, man = 1'b1, cont = 1'b0, stop = 1'b0, disp = 1'b0;
	logic        fast = 1'b1;
	int          xh = 0;
	logic        lset = 1'b0, lclr = 1'b0, stest = 1'b0, ssel = 1'b0, rq_q = 1'b0, ent_s;
	logic        done, iob, req, ent, ldr, ldp, ldt, skip, merr, mql, srl;
	logic [1:0]  lsel = 2'h0;
	logic [2:0]  sidx = 3'h0;
	logic [3:0]  creq = 4'h0, lat = 4'h1, ion = 4'h0, el = 4'h0, lamps, clamp, unit;
	logic [5:0]  sw = 6'h00;
	logic [6:0]  keys = 7'h00;
	logic [14:0] idx = 15'h0000, cnt, res, cw;
	logic [35:0] entry = 36'h0_0000_0000, sri = 36'h0_0000_0000, word, sro, mqo, word_s, sr_s, mq_s;
	logic [31:0] rs = 32'h0000_ee74, b;
	int          errors = 0, compares = 0, n_ex, n_mq, n_sr, n_rs, n_lp;
	cmc_console #(.TIME_DIV(DIV)) cmc_console_inst (
		.CLK_IN(clk), .RST_B_IN(rst_b), .KEYS_IN(keys), .MANUAL_IN(man),
		.CONT_ENTER_IN(cont), .FAST_IN(fast), .DISP_IND_IN(disp), .ENTRY_IN(entry), .SENSE_SW_IN(sw),
		.PROG_STOP_IN(stop), .EXEC_DONE_IN(done), .HALT_IN(1'b0), .IO_BUSY_IN(iob), .INDEX_IN(idx),
		.SR_IN(sri), .LAMP_SET_IN(lset), .LAMP_CLR_IN(lclr), .LAMP_SEL_IN(lsel),
		.SENSE_TEST_IN(stest), .SENSE_SW_SEL_IN(ssel), .SENSE_IDX_IN(sidx), .CYCLE_REQ_IN(creq),
		.EXEC_REQ_OUT(req), .EXEC_ENTRY_OUT(ent), .EXEC_WORD_OUT(word), .SR_LOAD_OUT(srl),
		.SR_OUT(sro), .MQ_LOAD_OUT(mql), .MQ_OUT(mqo), .LOAD_RESET_OUT(ldr), .LOAD_PULSE_OUT(ldp),
		.LOAD_TAPE_OUT(ldt), .LOAD_UNIT_OUT(unit), .LOAD_COUNT_OUT(cnt), .CPU_RESUME_OUT(res),
		.CHAN_CW_OUT(cw), .SKIP_OUT(skip), .SENSE_LAMP_OUT(lamps), .CYCLE_LAMP_OUT(clamp),
		.MULT_ERR_OUT(merr), .STOPPED_OUT());
	cmc_seq_model cmc_seq_model_inst (.clk_in(clk), .rst_b_in(rst_b), .req_in(req), .lat_in(lat),
		.io_n_in(ion), .done_out(done), .io_busy_out(iob));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [35:0] ea(input logic [35:0] s, input logic [14:0] x);
		return {s[35], 20'h0_0000, 15'(s[14:0] + ~x + 15'h0001)};
	endfunction
	function automatic logic me(input logic [3:0] c);
		return ($countones(c) > 1) && (c != 4'hc);
	endfunction
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// execute requests are counted on rising edges so a held request is not counted twice
	always @(posedge clk) begin
		rq_q <= req;
		if (req && !rq_q) begin
			n_ex++;
			ent_s = ent;
			word_s = word;
		end
		if (mql) begin
			n_mq++;
			mq_s = mqo;
		end
		if (srl) begin
			n_sr++;
			sr_s = sro;
		end
		n_rs = n_rs + int'(ldr);
		n_lp = n_lp + int'(ldp);
	end
	task automatic sense(input logic s, input logic [2:0] i, input logic e);
		@(posedge clk);
		stest <= 1'b1;
		ssel <= s;
		sidx <= i;
		@(posedge clk);
		stest <= 1'b0;
		#1;
		chk("skip", 36'(e), 36'(skip));
	endtask
	task automatic scen(input int k, input logic m, input logic s, input logic c, input int io,
		input int ex, input int mq, input int sr, input int ld);
		@(posedge clk);
		man <= m;
		stop <= s;
		cont <= c;
		ion <= 4'(io);
		lat <= 4'(xs()) & 4'h7;
		entry <= 36'({xs(), xs()});
		sri <= 36'({xs(), xs()});
		idx <= 15'(xs());
		repeat (8) @(posedge clk);
		#1;
		{n_ex, n_mq, n_sr, n_rs, n_lp} = '0;
		@(posedge clk);
		keys <= 7'h01 << k;
		repeat (HOLD + xh) @(posedge clk);
		keys <= 7'h00;
		repeat (300) @(posedge clk);
		#1;
		chk("exec count", 36'(ex), 36'(n_ex));
		chk("mq loads", 36'(mq), 36'(n_mq));
		chk("sr loads", 36'(sr), 36'(n_sr));
		chk("load resets", 36'(ld != 0), 36'(n_rs));
		if (ex != 0) chk("entry flag", 36'(k == 4 || c), 36'(ent_s));
		if (ex != 0 && (k == 4 || c)) chk("exec word", entry, word_s);
		if (mq != 0) chk("mq value", entry, mq_s);
		if (sr != 0) chk("eff addr", ea(sri, idx), sr_s);
		if (ld != 0) begin
			chk("tape", 36'(ld == 2), 36'(ldt));
			chk("count", 36'(`CMC_LOAD_WORDS), 36'(cnt));
			chk("resume", 36'(`CMC_RESUME_ADDR), 36'(res));
			chk("cw addr", 36'(`CMC_CW_ADDR), 36'(cw));
		end
		if (ld == 1) chk("pulse cycles", 36'(`CMC_CYC_SS1), 36'(n_lp));
		if (ld == 2) chk("unit", 36'(`CMC_LOAD_TAPE_UNIT), 36'(unit));
		$display("test key %0d done", k);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20 * HOLD) @(posedge clk);
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			b = xs();
			@(posedge clk);
			lset <= b[0];
			lclr <= !b[0];
			lsel <= b[2:1];
			@(posedge clk);
			lset <= 1'b0;
			lclr <= 1'b0;
			el[b[2:1]] = b[0];
			@(posedge clk);
			#1;
			chk("lamps", 36'(el), 36'(lamps));
			sense(1'b0, {1'b0, b[2:1]}, el[b[2:1]]);
		end
		@(posedge clk);
		sw <= 6'(xs());
		repeat (5) @(posedge clk);
		for (int i = 0; i < 6; i++) sense(1'b1, 3'(i), sw[i]);
		@(posedge clk);
		disp <= 1'b1;
		repeat (8) @(posedge clk);
		disp <= 1'b0;
		#1;
		chk("indicators", 36'(el), 36'(sr_s[3:0]));
		for (int i = 0; i < 30; i++) begin
			b = (i == 0) ? 32'h0000_000c : (i == 1) ? 32'h0000_0003 : xs();
			@(posedge clk);
			creq <= b[3:0];
			@(posedge clk);
			#1;
			chk("cycle lamps", 36'(b[3:0]), 36'(clamp));
			chk("multi error", 36'(me(b[3:0])), 36'(merr));
		end
		scen(1, 1'b1, 1'b0, 1'b0, 2, 3, 0, 0, 0);
		scen(1, 1'b1, 1'b1, 1'b0, 0, 0, 0, 0, 0);
		scen(1, 1'b1, 1'b0, 1'b1, 0, 1, 0, 0, 0);
		scen(2, 1'b1, 1'b1, 1'b0, 0, 1, 0, 0, 0);
		scen(2, 1'b1, 1'b0, 1'b0, 0, 0, 0, 0, 0);
		scen(3, 1'b0, 1'b0, 1'b0, 0, 0, 0, 0, 0);
		scen(3, 1'b1, 1'b0, 1'b0, 0, 0, 1, 0, 0);
		scen(4, 1'b1, 1'b0, 1'b0, 0, 1, 0, 0, 0);
		scen(0, 1'b1, 1'b0, 1'b0, 0, 0, 0, 1, 0);
		scen(5, 1'b1, 1'b0, 1'b0, 0, 0, 0, 0, 1);
		scen(6, 1'b1, 1'b0, 1'b0, 0, 0, 0, 0, 2);
		// held past one fast gap but not past a slow one
		xh = `CMC_CYC_FAST / DIV + 30;
		scen(2, 1'b1, 1'b1, 1'b0, 0, 2, 0, 0, 0);
		fast <= 1'b0;
		scen(2, 1'b1, 1'b1, 1'b0, 0, 1, 0, 0, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
